// >>> rtl/wps_pkg.sv
// Purpose: Shared constants for the waveform pattern sequencer
// Assumes: 16-bit registers behind a 15-bit serial address
// Notes:   Buffered registers are found through REG_ADDR
package wps_pkg;
  localparam int          AW       = 15;
  localparam int          DW       = 16;
  localparam int          HDR_BITS = 16;
  localparam int          FRM_BITS = 32;
  localparam int          RW_BIT   = 15;
  localparam logic [14:0] A_COMMIT = 15'h001d;
  localparam logic [14:0] A_CMD    = 15'h001e;
  localparam logic [14:0] A_RPT    = 15'h001f;
  localparam logic [14:0] A_TDLY   = 15'h0020;
  localparam logic [14:0] A_DOF    = 15'h0025;
  localparam logic [14:0] A_WAV    = 15'h0027;
  localparam logic [14:0] A_TB     = 15'h0028;
  localparam logic [14:0] A_PER    = 15'h0029;
  localparam logic [14:0] A_CNT    = 15'h002b;
  localparam logic [14:0] A_MKR    = 15'h002c;
  localparam logic [14:0] A_MKF    = 15'h002d;
  localparam logic [14:0] A_TSEL   = 15'h0044;
  localparam logic [14:0] A_SDLY   = 15'h005c;
  localparam logic [14:0] A_MEM    = 15'h6000;
  localparam int          NREG     = 11;
  localparam int          I_RPT    = 0;
  localparam int          I_TDLY   = 1;
  localparam int          I_DOF    = 2;
  localparam int          I_WAV    = 3;
  localparam int          I_TB     = 4;
  localparam int          I_PER    = 5;
  localparam int          I_CNT    = 6;
  localparam int          I_MKR    = 7;
  localparam int          I_MKF    = 8;
  localparam int          I_TSEL   = 9;
  localparam int          I_SDLY   = 10;
  localparam logic [14:0] REG_ADDR [NREG] = '{A_RPT, A_TDLY, A_DOF,
    A_WAV, A_TB, A_PER, A_CNT, A_MKR, A_MKF, A_TSEL, A_SDLY};
  localparam logic [15:0] REG_RST [NREG] = '{16'h0000, 16'h000e,
    16'h0000, 16'h0101, 16'h0111, 16'h8000, 16'h0101, 16'h0003,
    16'h0000, 16'h0000, 16'h0000};
  localparam int          B_UPDATE = 0;
  localparam int          B_RUN    = 0;
  localparam int          B_PLAY   = 1;
  localparam int          B_MEM    = 2;
  localparam int          B_BUFRD  = 3;
  localparam int          B_REPEAT = 0;
  localparam int          B_ONESHOT = 1;
  localparam int          B_CHSUM  = 2;
  localparam logic [15:0] CNT_ONE  = 16'h0001;
  localparam logic [15:0] MK_FIRE  = 16'h0002;
  typedef enum logic [1:0] {S_IDLE, S_TDLY, S_LEAD, S_PLAY} wps_state_t;
  typedef enum logic [1:0] {MK_IDLE, MK_RISE, MK_FALL} wps_mark_t;
endpackage

// >>> rtl/wps_fifo.sv
// Purpose: Sample FIFO between the sequencer and the DAC side
// Assumes: Depth is a power of two
// Notes:   Full drops in_ready, which stalls the pattern timing
`timescale 1ns/1ps
module wps_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int PW = $clog2(D);

  if (D < 2 || (D & (D - 1)) != 0) begin : g_chk
    $error("wps_fifo depth must be a power of two");
  end

  logic [W-1:0] mem_q [D];
  logic [W-1:0] mem_d [D];
  logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [PW:0]   cnt_q, cnt_d;
  logic          push, pop;

  assign in_ready  = cnt_q != (PW + 1)'(D);
  assign out_valid = cnt_q != '0;
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    mem_d = mem_q;
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wp_q] = in_data;
      wp_d        = wp_q + PW'(1);
    end
    if (pop) begin
      rp_d = rp_q + PW'(1);
    end
    if (push && !pop) begin
      cnt_d = cnt_q + (PW + 1)'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - (PW + 1)'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < D; i++) begin
        mem_q[i] <= '0;
      end
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      mem_q <= mem_d;
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule // wps_fifo

// >>> rtl/wps_top.sv
// Purpose: Waveform pattern sequencer control behind a serial port
// Assumes: Serial clock well below clk; memory read is combinational
// Notes:   Samples leave as {wave sel, builtin sel, index} words
//
// Overview of operation
// - Update bit copies all pending settings to active; it reads back zero.
// - With readback-select set, reads return active rather than pending values.
// - Waveform memory access over the serial port only while enable set.
// - Status bit 1 shows whether a pattern is playing.
// - Run bit permits playback; clearing it stops the pattern at once.
// - Repeat mode 0 loops forever; 1 plays the programmed count.
// - Pattern starts delay plus one clocks after trigger falls.
// - Builtin select chooses constant, sawtooth, pseudorandom or DDS.
// - Wave select chooses RAM, builtin, gated builtin or modulated.
// - Channel sum bit clear means normal data path.
// - Each sample holds for hold field plus one periods.
// - Period scale sets clocks per cycle-length unit, zero meaning one.
// - Lead-in scale sets clocks per start-delay unit, zero meaning one.
// - Replay count plays the pattern field plus one times.
// - Marker rises the programmed cycles after trigger falls.
// - Marker falls the programmed cycles after the pattern ends.
// - One-shot lead-in applies start delay before the first pattern only.
`timescale 1ns/1ps
module wps_top
  import wps_pkg::*;
#(
  parameter int IDX_W  = 12,
  parameter int FIFO_D = 8
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          spi_cs_n,
  input  wire logic          spi_sclk,
  input  wire logic          spi_sdi,
  output logic               spi_sdo,
  output logic               spi_sdo_oe,
  input  wire logic          trigger_n,
  output logic               marker,
  output logic               playing,
  output logic               chan_sum,
  output logic [11:0]        dig_offset,
  output logic [IDX_W-1:0]   mem_addr,
  output logic [DW-1:0]      mem_wdata,
  output logic               mem_we,
  input  wire logic [DW-1:0] mem_rdata,
  output logic [DW-1:0]      smp_data,
  output logic               smp_valid,
  input  wire logic          smp_ready
);
  if (IDX_W < 1 || IDX_W > 12) begin : g_chk
    $error("wps_top IDX_W must be 1 to 12");
  end

  function automatic logic [3:0] reg_index(input logic [AW-1:0] a);
    reg_index = 4'(NREG);
    for (int i = 0; i < NREG; i++) begin
      if (a == REG_ADDR[i]) begin
        reg_index = 4'(i);
      end
    end
  endfunction

  // Pin synchronisers
  logic [2:0]    cs_s, sck_s, trg_s;
  logic [1:0]    sdi_s;
  logic          sel, sck_rise, sck_fall, trig_fall;

  // Serial port state
  logic [5:0]    bc_q, bc_d;
  logic [DW-2:0] sh_q, sh_d;
  logic [DW-1:0] out_q, out_d, wd_q, wd_d, rd_val;
  logic [AW-1:0] addr_q, addr_d;
  logic          sdo_q, sdo_d, oe_q, oe_d, rd_q, rd_d;
  logic          ld_q, ld_d, wr_q, wr_d;

  // Register state
  logic [DW-1:0] pend_q [NREG];
  logic [DW-1:0] pend_d [NREG];
  logic [DW-1:0] act_q  [NREG];
  logic [DW-1:0] act_d  [NREG];
  logic          run_q, run_d, memen_q, memen_d, bufrd_q, bufrd_d;
  logic [3:0]    widx, ridx;

  // Sequencer state
  wps_state_t    st_q, st_d;
  wps_mark_t     mka_q, mka_d;
  logic [15:0]   cnt_q, cnt_d, mkc_q, mkc_d;
  logic [3:0]    pre_q, pre_d, hold_q, hold_d;
  logic [IDX_W-1:0] idx_q, idx_d;
  logic [7:0]    rep_q, rep_d;
  logic          first_q, first_d, mk_q, mk_d;
  logic          start_pat, pat_end, push, fifo_rdy;

  // Active fields
  logic          rpt_mode, oneshot;
  logic [15:0]   tdly, per, sdly, mkr;
  logic [3:0]    hold, psc, lsc, mkf, psc_m1, lsc_m1;
  logic [1:0]    wsel, bsel;
  logic [7:0]    cnt_lim;

  assign rpt_mode = act_q[I_RPT][B_REPEAT];
  assign tdly     = act_q[I_TDLY];
  assign wsel     = act_q[I_WAV][1:0];
  assign bsel     = act_q[I_WAV][5:4];
  assign hold     = act_q[I_TB][11:8];
  assign psc      = act_q[I_TB][7:4];
  assign lsc      = act_q[I_TB][3:0];
  assign per      = act_q[I_PER];
  assign cnt_lim  = act_q[I_CNT][7:0];
  assign mkr      = act_q[I_MKR];
  assign mkf      = act_q[I_MKF][3:0];
  assign oneshot  = act_q[I_TSEL][B_ONESHOT];
  assign sdly     = act_q[I_SDLY];
  assign psc_m1   = (psc == '0) ? '0 : psc - 4'h1;
  assign lsc_m1   = (lsc == '0) ? '0 : lsc - 4'h1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_s  <= '1;
      trg_s <= '1;
      sck_s <= '0;
      sdi_s <= '0;
    end else begin
      cs_s  <= {cs_s[1:0], spi_cs_n};
      trg_s <= {trg_s[1:0], trigger_n};
      sck_s <= {sck_s[1:0], spi_sclk};
      sdi_s <= {sdi_s[0], spi_sdi};
    end
  end

  assign sel       = !cs_s[1];
  assign sck_rise  = sck_s[1] && !sck_s[2];
  assign sck_fall  = !sck_s[1] && sck_s[2];
  assign trig_fall = trg_s[2] && !trg_s[1];

  // Frame: 16-bit header (read flag, address) then 16 data bits
  always_comb begin
    bc_d   = bc_q;
    sh_d   = sh_q;
    out_d  = out_q;
    sdo_d  = sdo_q;
    oe_d   = oe_q;
    rd_d   = rd_q;
    addr_d = addr_q;
    wd_d   = wd_q;
    ld_d   = 1'b0;
    wr_d   = 1'b0;
    if (!sel) begin
      bc_d = '0;
      oe_d = 1'b0;
      rd_d = 1'b0;
    end else if (sck_rise) begin
      sh_d = {sh_q[DW-3:0], sdi_s[1]};
      bc_d = bc_q + 6'h01;
      if (bc_q == 6'(HDR_BITS - 1)) begin
        rd_d   = sh_q[RW_BIT-1];
        ld_d   = sh_q[RW_BIT-1];
        addr_d = {sh_q[AW-2:0], sdi_s[1]};
      end
      if (bc_q == 6'(FRM_BITS - 1) && !rd_q) begin
        wr_d = 1'b1;
        wd_d = {sh_q, sdi_s[1]};
      end
    end else if (sck_fall && rd_q && bc_q >= 6'(HDR_BITS)) begin
      sdo_d = out_q[DW-1];
      out_d = {out_q[DW-2:0], 1'b0};
      oe_d  = 1'b1;
    end
    if (ld_q) begin
      out_d = rd_val;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bc_q   <= '0;
      sh_q   <= '0;
      out_q  <= '0;
      sdo_q  <= 1'b0;
      oe_q   <= 1'b0;
      rd_q   <= 1'b0;
      addr_q <= '0;
      wd_q   <= '0;
      ld_q   <= 1'b0;
      wr_q   <= 1'b0;
    end else begin
      bc_q   <= bc_d;
      sh_q   <= sh_d;
      out_q  <= out_d;
      sdo_q  <= sdo_d;
      oe_q   <= oe_d;
      rd_q   <= rd_d;
      addr_q <= addr_d;
      wd_q   <= wd_d;
      ld_q   <= ld_d;
      wr_q   <= wr_d;
    end
  end

  assign widx = reg_index(addr_q);
  assign ridx = widx;

  always_comb begin
    rd_val = '0;
    if (addr_q == A_CMD) begin
      rd_val[B_BUFRD] = bufrd_q;
      rd_val[B_MEM]   = memen_q;
      rd_val[B_PLAY]  = playing;
      rd_val[B_RUN]   = run_q;
    end else if (addr_q >= A_MEM) begin
      if (memen_q) begin
        rd_val = mem_rdata;
      end
    end else if (ridx != 4'(NREG)) begin
      rd_val = bufrd_q ? act_q[ridx] : pend_q[ridx];
    end
  end

  always_comb begin
    pend_d  = pend_q;
    act_d   = act_q;
    run_d   = run_q;
    memen_d = memen_q;
    bufrd_d = bufrd_q;
    if (wr_q) begin
      if (addr_q == A_COMMIT) begin
        if (wd_q[B_UPDATE]) begin
          act_d = pend_q;
        end
      end else if (addr_q == A_CMD) begin
        run_d   = wd_q[B_RUN];
        memen_d = wd_q[B_MEM];
        bufrd_d = wd_q[B_BUFRD];
      end else if (widx != 4'(NREG)) begin
        pend_d[widx] = wd_q;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NREG; i++) begin
        pend_q[i] <= REG_RST[i];
        act_q[i]  <= REG_RST[i];
      end
      run_q   <= 1'b0;
      memen_q <= 1'b0;
      bufrd_q <= 1'b0;
    end else begin
      pend_q  <= pend_d;
      act_q   <= act_d;
      run_q   <= run_d;
      memen_q <= memen_d;
      bufrd_q <= bufrd_d;
    end
  end

  // Full FIFO freezes the whole play timing, so no sample is dropped
  always_comb begin
    st_d      = st_q;
    cnt_d     = cnt_q;
    pre_d     = pre_q;
    hold_d    = hold_q;
    idx_d     = idx_q;
    rep_d     = rep_q;
    first_d   = first_q;
    mk_d      = mk_q;
    mka_d     = mka_q;
    mkc_d     = mkc_q;
    start_pat = 1'b0;
    pat_end   = 1'b0;
    if (mka_q != MK_IDLE) begin
      if (mkc_q <= MK_FIRE) begin
        mk_d  = (mka_q == MK_RISE);
        mka_d = MK_IDLE;
      end else begin
        mkc_d = mkc_q - CNT_ONE;
      end
    end
    case (st_q)
      S_IDLE: if (trig_fall) begin
        rep_d   = '0;
        first_d = 1'b1;
        if (mkr <= CNT_ONE) begin
          mk_d = 1'b1;
        end else begin
          mka_d = MK_RISE;
          mkc_d = mkr;
        end
        if (tdly == '0) begin
          start_pat = 1'b1;
        end else begin
          st_d  = S_TDLY;
          cnt_d = tdly - CNT_ONE;
        end
      end
      S_TDLY: if (cnt_q == '0) begin
        start_pat = 1'b1;
      end else begin
        cnt_d = cnt_q - CNT_ONE;
      end
      S_LEAD: if (pre_q == lsc_m1) begin
        pre_d = '0;
        if (cnt_q == '0) begin
          st_d  = S_PLAY;
          cnt_d = per - CNT_ONE;
        end else begin
          cnt_d = cnt_q - CNT_ONE;
        end
      end else begin
        pre_d = pre_q + 4'h1;
      end
      S_PLAY: if (fifo_rdy) begin
        hold_d = (hold_q == hold) ? '0 : hold_q + 4'h1;
        if (hold_q == '0) begin
          idx_d = idx_q + IDX_W'(1);
        end
        if (pre_q == psc_m1) begin
          pre_d = '0;
          if (cnt_q == '0) begin
            pat_end = 1'b1;
          end else begin
            cnt_d = cnt_q - CNT_ONE;
          end
        end else begin
          pre_d = pre_q + 4'h1;
        end
      end
      default: st_d = S_IDLE;
    endcase
    if (pat_end) begin
      rep_d   = rep_q + 8'h01;
      first_d = 1'b0;
      if (rpt_mode && rep_q == cnt_lim) begin
        st_d = S_IDLE;
        if (mkf <= 4'h1) begin
          mk_d  = 1'b0;
          mka_d = MK_IDLE;
        end else begin
          mka_d = MK_FALL;
          mkc_d = 16'(mkf);
        end
      end else begin
        start_pat = 1'b1;
      end
    end
    if (start_pat) begin
      pre_d  = '0;
      hold_d = '0;
      idx_d  = '0;
      if (sdly != '0 && (!oneshot || first_d)) begin
        st_d  = S_LEAD;
        cnt_d = sdly - CNT_ONE;
      end else begin
        st_d  = S_PLAY;
        cnt_d = per - CNT_ONE;
      end
    end
    if (!run_q) begin
      st_d  = S_IDLE;
      mk_d  = 1'b0;
      mka_d = MK_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= S_IDLE;
      cnt_q   <= '0;
      pre_q   <= '0;
      hold_q  <= '0;
      idx_q   <= '0;
      rep_q   <= '0;
      first_q <= 1'b0;
      mk_q    <= 1'b0;
      mka_q   <= MK_IDLE;
      mkc_q   <= '0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      pre_q   <= pre_d;
      hold_q  <= hold_d;
      idx_q   <= idx_d;
      rep_q   <= rep_d;
      first_q <= first_d;
      mk_q    <= mk_d;
      mka_q   <= mka_d;
      mkc_q   <= mkc_d;
    end
  end

  assign push = (st_q == S_PLAY) && (hold_q == '0) && run_q;

  wps_fifo #(
    .W (DW),
    .D (FIFO_D)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   ({wsel, bsel, 12'(idx_q)}),
    .in_valid  (push),
    .in_ready  (fifo_rdy),
    .out_data  (smp_data),
    .out_valid (smp_valid),
    .out_ready (smp_ready)
  );

  assign playing    = (st_q == S_LEAD) || (st_q == S_PLAY);
  assign marker     = mk_q;
  assign chan_sum   = act_q[I_WAV][B_CHSUM];
  assign dig_offset = act_q[I_DOF][15:4];
  assign spi_sdo    = sdo_q;
  assign spi_sdo_oe = oe_q;
  assign mem_addr   = addr_q[IDX_W-1:0];
  assign mem_wdata  = wd_q;
  assign mem_we     = wr_q && addr_q >= A_MEM && memen_q;

  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);

  commit_copy_a: assert property (
    wr_q && addr_q == A_COMMIT && wd_q[B_UPDATE]
    |=> act_q[I_PER] == $past(pend_q[I_PER]))
    else $error("update did not copy pending settings");
  buf_read_a: assert property (
    ld_q && bufrd_q && addr_q == A_TDLY |=> out_q == $past(act_q[I_TDLY]))
    else $error("readback did not return active value");
  mem_grant_a: assert property (
    wr_q && addr_q >= A_MEM && !memen_q |-> !mem_we)
    else $error("memory write without access enable");
  run_stop_a: assert property (
    !run_q |=> st_q == S_IDLE && !mk_q)
    else $error("pattern kept running without run");
  trig_delay_a: assert property (
    trig_fall && st_q == S_IDLE && run_q && tdly == 16'h0002
    ##1 run_q [*2] |=> playing)
    else $error("pattern start not at delay plus one");
  hold_rate_a: assert property (
    push && fifo_rdy && hold == 4'h1 |=> !push)
    else $error("sample not held for two periods");
  rpt_done_a: assert property (
    pat_end && rpt_mode && rep_q == cnt_lim && run_q |=> st_q == S_IDLE)
    else $error("pattern did not stop after replay count");
  loop_on_a: assert property (
    pat_end && !rpt_mode && run_q |=> playing)
    else $error("continuous pattern stopped");
  one_shot_a: assert property (
    pat_end && oneshot && sdly != 16'h0000 && run_q
    && !(rpt_mode && rep_q == cnt_lim) |=> st_q == S_PLAY)
    else $error("lead-in repeated in one-shot mode");
  marker_rise_a: assert property (
    trig_fall && st_q == S_IDLE && run_q && !mk_q && mkr == 16'h0005
    ##1 run_q [*4] |=> $rose(mk_q))
    else $error("marker did not rise on time");
  marker_fall_a: assert property (
    pat_end && rpt_mode && rep_q == cnt_lim && run_q && mkf == 4'h3
    ##1 run_q [*2] |=> !mk_q && $past(mk_q))
    else $error("marker did not fall on time");
endmodule // wps_top

// >>> dv/wps_host_model.sv
// Purpose: Host controller model on the serial register port
// Assumes: Serial clock high phase lasts PH clk cycles, low phase PH plus one
// Notes:   Data line shows the inverse of its last bit when deselected
`timescale 1ns/1ps
module wps_host_model (
  input  wire logic clk,
  output logic      spi_cs_n,
  output logic      spi_sclk,
  output logic      spi_sdi,
  input  wire logic spi_sdo
);
  localparam int PH = 6;
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_sdi  = 1'b0;
  end
  // One access per select period, select raised between frames
  task automatic xfer(input logic rd, input logic [14:0] a,
                      input logic [15:0] wd, output logic [15:0] q);
    logic [31:0] f;
    f = {rd, a, wd};
    q = '0;
    @(posedge clk) spi_cs_n <= 1'b0;
    for (int i = 31; i >= 0; i--) begin
      @(posedge clk) spi_sdi <= f[i];
      repeat (PH) @(posedge clk);
      if (i < 16) q = {q[14:0], spi_sdo};
      spi_sclk <= 1'b1;
      repeat (PH) @(posedge clk);
      spi_sclk <= 1'b0;
    end
    repeat (PH) @(posedge clk);
    spi_cs_n <= 1'b1;
    spi_sdi  <= ~f[0];
    repeat (PH) @(posedge clk);
  endtask
endmodule // wps_host_model

// >>> dv/waveform_pattern_sequencer_ctrl_tb_top.sv
// Purpose: Self-checking bench for the pattern sequencer control
// Assumes: Host model owns the serial pins, bench owns trigger and sink
// Notes:   Trigger sync latency is unknown, so starts are compared
`timescale 1ns/1ps
module waveform_pattern_sequencer_ctrl_tb_top;
  import wps_pkg::*;
  logic          clk, rst_n, spi_cs_n, spi_sclk, spi_sdi, spi_sdo;
  logic          spi_sdo_oe, trigger_n, marker, playing, chan_sum;
  logic          mem_we, smp_valid, smp_ready, play_d, mark_d, trg_d;
  logic [11:0]   dig_offset, mem_addr, we_addr;
  logic [DW-1:0] mem_wdata, mem_rdata, smp_data, first_smp, we_data, q;
  int            n_mismatch, checks, cyc, n_play, n_mark, n_smp, n_we;
  int            t_play, t_mark, t0, t_trg, n_oe;

  assign mem_rdata = {4'ha, mem_addr};

  wps_top uut (.clk(clk), .rst_n(rst_n), .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe), .trigger_n(trigger_n), .marker(marker),
    .playing(playing), .chan_sum(chan_sum), .dig_offset(dig_offset),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
    .mem_rdata(mem_rdata), .smp_data(smp_data),
    .smp_valid(smp_valid), .smp_ready(smp_ready));
  wps_host_model host (.clk(clk), .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (playing === 1'b1) n_play++;
    if (spi_sdo_oe === 1'b1) n_oe++;
    // Trigger edge as seen here, so start times share one reference
    if (trigger_n === 1'b0 && trg_d !== 1'b0) t_trg = cyc;
    trg_d = trigger_n;
    if (marker === 1'b1) n_mark++;
    if (playing === 1'b1 && play_d !== 1'b1) t_play = cyc;
    if (marker === 1'b1 && mark_d !== 1'b1) t_mark = cyc;
    play_d = playing;
    mark_d = marker;
    if (smp_valid === 1'b1 && smp_ready === 1'b1) begin
      if (n_smp == 0) first_smp = smp_data;
      n_smp++;
    end
    if (mem_we === 1'b1) begin
      n_we++;
      we_addr = mem_addr;
      we_data = mem_wdata;
    end
    if (cyc == 80000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (e !== g) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [14:0] a, logic [15:0] d);
    n_oe = 0;
    host.xfer(1'b0, a, d, q);
    chk("sdo_oe on write", 0, n_oe);
  endtask
  task automatic rdc(string nm, logic [14:0] a, logic [15:0] e);
    n_oe = 0;
    host.xfer(1'b1, a, 16'h0000, q);
    chk(nm, e, q);
    chk("sdo_oe on read", 1, n_oe > 0);
  endtask
  task automatic trig_go;
    n_play = 0;
    n_mark = 0;
    n_smp = 0;
    trigger_n <= 1'b0;
    repeat (4) @(posedge clk);
    trigger_n <= 1'b1;
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk);
      if (n_play > 0 && playing === 1'b0 && marker === 1'b0) break;
    end
    repeat (4) @(posedge clk);
  endtask

  task automatic t_reset;
    for (int i = 0; i < NREG; i++)
      rdc("reset value", REG_ADDR[i], REG_RST[i]);
    rdc("command reg", A_CMD, 16'h0000);
    chk("chan_sum", 0, chan_sum);
    chk("dig_offset", 0, dig_offset);
    $display("test reset done");
  endtask

  task automatic t_buffer;
    wr(A_TDLY, 16'h0005);
    wr(A_CMD, 16'h0008);
    rdc("active delay", A_TDLY, 16'h000e);
    wr(A_CMD, 16'h0000);
    rdc("pending delay", A_TDLY, 16'h0005);
    wr(A_DOF, 16'habc0);
    wr(A_WAV, 16'h0104);
    wr(A_COMMIT, 16'h0001);
    rdc("update bit", A_COMMIT, 16'h0000);
    chk("dig_offset", 12'habc, dig_offset);
    chk("chan_sum", 1, chan_sum);
    wr(A_WAV, 16'h0100);
    wr(A_COMMIT, 16'h0001);
    chk("chan_sum", 0, chan_sum);
    wr(A_CMD, 16'h0008);
    rdc("active delay", A_TDLY, 16'h0005);
    wr(A_CMD, 16'h0000);
    rdc("unmapped", 15'h0030, 16'h0000);
    $display("test buffer done");
  endtask

  task automatic t_mem;
    n_we = 0;
    wr(A_MEM + 15'h3, 16'hbeef);
    chk("blocked writes", 0, n_we);
    rdc("blocked read", A_MEM + 15'h7, 16'h0000);
    wr(A_CMD, 16'h0004);
    wr(A_MEM + 15'h3, 16'hbeef);
    chk("mem writes", 1, n_we);
    chk("mem addr", 12'h003, we_addr);
    chk("mem data", 16'hbeef, we_data);
    rdc("mem read", A_MEM + 15'h7, 16'ha007);
    wr(A_CMD, 16'h0000);
    $display("test memory done");
  endtask

  task automatic t_sources;
    wr(A_RPT, 16'h0001);
    wr(A_CNT, 16'h0001);
    wr(A_PER, 16'h0002);
    wr(A_TB, 16'h0000);
    wr(A_MKR, 16'h0005);
    wr(A_MKF, 16'h0003);
    for (int k = 0; k < 4; k++) begin
      wr(A_TDLY, 16'(2 + 4 * k));
      wr(A_WAV, {8'h01, 2'b00, k[1:0], 2'b00, k[1:0]});
      wr(A_COMMIT, 16'h0001);
      if (k == 0) wr(A_CMD, 16'h0001);
      trig_go();
      wait_idle();
      if (k == 0) t0 = t_play - t_trg;
      chk("marker lead", 2 - 4 * k, t_mark - t_play);
      chk("play start", 4 * k, t_play - t_trg - t0);
      chk("source", {k[1:0], k[1:0]}, first_smp[15:12]);
      chk("first index", 0, first_smp[11:0]);
      chk("play cycles", 4, n_play);
      chk("samples", 4, n_smp);
      chk("marker cycles", 4 * k + 4, n_mark);
    end
    $display("test sources done");
  endtask

  task automatic t_lead;
    wr(A_TDLY, 16'h0002);
    wr(A_WAV, 16'h0101);
    wr(A_TB, 16'h0002);
    wr(A_SDLY, 16'h0002);
    wr(A_COMMIT, 16'h0001);
    trig_go();
    wait_idle();
    chk("lead each", 12, n_play);
    wr(A_TSEL, 16'h0002);
    wr(A_COMMIT, 16'h0001);
    trig_go();
    wait_idle();
    chk("lead once", 8, n_play);
    $display("test lead-in done");
  endtask

  task automatic t_fifo;
    wr(A_CNT, 16'h0000);
    wr(A_TB, 16'h0120);
    wr(A_PER, 16'h000a);
    wr(A_SDLY, 16'h0000);
    wr(A_COMMIT, 16'h0001);
    smp_ready <= 1'b0;
    trig_go();
    repeat (120) @(posedge clk);
    chk("stalled play", 1, playing);
    chk("queued", 1, smp_valid);
    smp_ready <= 1'b1;
    wait_idle();
    chk("held samples", 10, n_smp);
    $display("test fifo done");
  endtask

  task automatic t_run;
    wr(A_RPT, 16'h0000);
    wr(A_TB, 16'h0000);
    wr(A_PER, 16'h0004);
    wr(A_COMMIT, 16'h0001);
    trig_go();
    repeat (60) @(posedge clk);
    rdc("status", A_CMD, 16'h0003);
    wr(A_CMD, 16'h0000);
    repeat (3) @(posedge clk);
    chk("playing", 0, playing);
    chk("marker", 0, marker);
    rdc("status", A_CMD, 16'h0000);
    $display("test run done");
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    trigger_n = 1'b1;
    smp_ready = 1'b1;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_buffer();
    t_mem();
    t_sources();
    t_lead();
    t_fifo();
    t_run();
    print_verdict();
  end
endmodule // waveform_pattern_sequencer_ctrl_tb_top
